// ===== rtl/bsf_top.sv
// module: block-sync flywheel, status flags, sleep timer and interrupt line
`timescale 1ns/10ps
`default_nettype none
module bsf_top #(
   parameter int unsigned TICK_CYCLES = bsf_pkg::TICK_CYCLES,
   parameter int unsigned BLOCK_BITS = bsf_pkg::BLOCK_BITS
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire bsf_pkg::bsf_rx_t i_rx,
   input wire bsf_pkg::bsf_timer_wr_t i_timer_wr,
   input wire logic i_flags_rd,
   input wire logic [7:0] i_irq_mask,
   output logic [7:0] o_status,
   output logic [7:0] o_flags,
   output logic o_symbols_valid,
   output logic o_search,
   output logic o_interrupt_line_n_out,
   output logic o_interrupt_line_n_oe
);
   // ----------------------------------------------------------------------------
   // flywheel
   // ----------------------------------------------------------------------------
   bsf_pkg::bsf_state_t st_q, st_d;
   logic [9:0] bitcnt_q, bitcnt_d;
   logic [7:0] status_q, status_d;
   logic [7:0] flags_q, flags_d;
   logic [7:0] secs_q, secs_d;
   logic running_q, running_d;
   logic irq_q, irq_d;
   logic search_q, search_d;
   logic tick;
   logic expire;
   logic timer_done;

   assign expire = (st_q == bsf_pkg::BSF_LOCKED) && i_rx.bit_valid &&
      (bitcnt_q == 10'(BLOCK_BITS + bsf_pkg::SYNC_WINDOW - 1));

   always_comb begin
      st_d = st_q;
      bitcnt_d = bitcnt_q;
      status_d = status_q;
      flags_d = flags_q;
      if (i_flags_rd) begin
         flags_d = bsf_pkg::FLAGS_RST;
      end
      case (st_q)
         bsf_pkg::BSF_SEARCH: begin
            if (i_rx.sync_found) begin
               st_d = bsf_pkg::BSF_LOCKED;
               bitcnt_d = 10'h000;
               status_d[bsf_pkg::ST_LOCK_BIT] = 1'b1;
               flags_d[bsf_pkg::FL_SYNC_BIT] = 1'b1;
            end
         end
         bsf_pkg::BSF_LOCKED: begin
            if (i_rx.sync_found) begin
               bitcnt_d = 10'h000;
               flags_d[bsf_pkg::FL_SYNC_BIT] = 1'b1;
            end else if (expire) begin
               st_d = bsf_pkg::BSF_SEARCH;
               flags_d[bsf_pkg::FL_SYNC_BIT] = 1'b1;
               status_d = bsf_pkg::STATUS_RST;
            end else if (i_rx.bit_valid) begin
               bitcnt_d = bitcnt_q + 10'h001;
               // flags update as their positions are counted in
               if (bitcnt_q == 10'(bsf_pkg::DEC_POS)) begin
                  status_d[bsf_pkg::ST_DEC_BIT] = i_rx.bit_value;
                  flags_d[bsf_pkg::FL_DEC_BIT] = 1'b1;
               end
               if (bitcnt_q == 10'(bsf_pkg::IDLE_POS)) begin
                  status_d[bsf_pkg::ST_IDLE_BIT] = i_rx.bit_value;
                  flags_d[bsf_pkg::FL_IDLE_BIT] = 1'b1;
               end
            end
         end
         default: begin
            st_d = bsf_pkg::BSF_SEARCH;
         end
      endcase
      search_d = (st_d == bsf_pkg::BSF_SEARCH);
      // set wins over the read-clear
      if (timer_done) begin
         flags_d[bsf_pkg::FL_TIME_BIT] = 1'b1;
      end
   end

   // search gets a flop of its own so the pin never decodes the state word
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_q <= bsf_pkg::BSF_SEARCH;
         bitcnt_q <= 10'h000;
         status_q <= bsf_pkg::STATUS_RST;
         flags_q <= bsf_pkg::FLAGS_RST;
         search_q <= 1'b1;
      end else begin
         st_q <= st_d;
         bitcnt_q <= bitcnt_d;
         status_q <= status_d;
         flags_q <= flags_d;
         search_q <= search_d;
      end
   end

   // ----------------------------------------------------------------------------
   // sleep timer
   // ----------------------------------------------------------------------------
   bsf_tick_div #(
      .DIV(TICK_CYCLES)
   ) u_div (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_restart(i_timer_wr.wr_valid),
      .o_tick(tick)
   );

   assign timer_done = running_q && tick && (secs_q == 8'h01) && !i_timer_wr.wr_valid;

   always_comb begin
      secs_d = secs_q;
      running_d = running_q;
      if (i_timer_wr.wr_valid) begin
         secs_d = i_timer_wr.seconds;
         running_d = (i_timer_wr.seconds != 8'h00);
      end else if (running_q && tick) begin
         secs_d = secs_q - 8'h01;
         if (secs_q == 8'h01) begin
            running_d = 1'b0;
         end
      end
   end

   // load and divider restart share one edge, so the first second is a whole one
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         secs_q <= 8'h00;
         running_q <= 1'b0;
      end else begin
         secs_q <= secs_d;
         running_q <= running_d;
      end
   end

   // ----------------------------------------------------------------------------
   // interrupt line: pending flags gated by mask
   // ----------------------------------------------------------------------------
   always_comb begin
      irq_d = |(flags_d & i_irq_mask);
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign o_status = status_q;
   assign o_flags = flags_q;
   assign o_symbols_valid = status_q[bsf_pkg::ST_LOCK_BIT];
   assign o_search = search_q;
   assign o_interrupt_line_n_out = 1'b0;
   assign o_interrupt_line_n_oe = irq_q;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   a_loss_clears_lock: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      expire && !i_rx.sync_found |=> !o_status[bsf_pkg::ST_LOCK_BIT] &&
      o_flags[bsf_pkg::FL_SYNC_BIT]) else $error("sync loss not reported");
   a_read_clears_time: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      i_flags_rd && !timer_done |=> !o_flags[bsf_pkg::FL_TIME_BIT])
      else $error("timeout flag not cleared by read");
   a_timer_sets_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      timer_done |=> o_flags[bsf_pkg::FL_TIME_BIT]) else $error("timeout flag not set");
   a_load_starts: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      i_timer_wr.wr_valid && i_timer_wr.seconds != 8'h00 |=> running_q &&
      secs_q == $past(i_timer_wr.seconds)) else $error("countdown not loaded");
   a_mask_gates_irq: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      timer_done && !i_irq_mask[bsf_pkg::FL_TIME_BIT] &&
      (flags_d & i_irq_mask & 8'hf7) == 8'h00 |=> !o_interrupt_line_n_oe)
      else $error("masked timer interrupt reached line");
   a_mask_passes_irq: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      timer_done && i_irq_mask[bsf_pkg::FL_TIME_BIT] |=> o_interrupt_line_n_oe)
      else $error("unmasked timer interrupt missing");
   a_oe_needs_flag: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_interrupt_line_n_oe |-> (o_flags & $past(i_irq_mask)) != 8'h00)
      else $error("interrupt line active without a masked-in flag");
   a_sync_restarts: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      st_q == bsf_pkg::BSF_LOCKED && i_rx.sync_found |=> bitcnt_q == 10'h000 && !o_search)
      else $error("early sync did not restart prediction");
   a_dec_capture: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      st_q == bsf_pkg::BSF_LOCKED && i_rx.bit_valid && !i_rx.sync_found && !expire &&
      bitcnt_q == 10'(bsf_pkg::DEC_POS) |=>
      o_status[bsf_pkg::ST_DEC_BIT] == $past(i_rx.bit_value))
      else $error("decode flag not captured");
   a_idle_capture: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      st_q == bsf_pkg::BSF_LOCKED && i_rx.bit_valid && !i_rx.sync_found && !expire &&
      bitcnt_q == 10'(bsf_pkg::IDLE_POS) |=>
      o_status[bsf_pkg::ST_IDLE_BIT] == $past(i_rx.bit_value))
      else $error("idle flag not captured");
   a_tick_decrements: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      running_q && tick && !i_timer_wr.wr_valid |=> secs_q == $past(secs_q) - 8'h01)
      else $error("countdown did not step");
   a_timer_holds_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !running_q && !i_timer_wr.wr_valid |=> $stable(secs_q))
      else $error("stopped countdown moved");
   a_flags_sticky: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      !i_flags_rd |=> (o_flags & $past(o_flags)) == $past(o_flags))
      else $error("pending flag dropped without a read");
   a_search_holds_status: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_search && !i_rx.sync_found |=> o_search && $stable(o_status))
      else $error("status changed while searching");
   a_lock_on_sync: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      o_search && i_rx.sync_found |=> !o_search && o_status[bsf_pkg::ST_LOCK_BIT] &&
      o_flags[bsf_pkg::FL_SYNC_BIT]) else $error("first sync did not lock");
   a_loss_to_search: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      expire && !i_rx.sync_found |=> o_search && !o_symbols_valid)
      else $error("sync loss did not return to search");
   a_count_steps: assert property (@(posedge i_clk) disable iff (!i_arst_n)
      st_q == bsf_pkg::BSF_LOCKED && i_rx.bit_valid && !i_rx.sync_found && !expire |=>
      bitcnt_q == $past(bitcnt_q) + 10'h001) else $error("bit counter did not step");

   // ----------------------------------------------------------------------------
   // coverage
   // ----------------------------------------------------------------------------
   c_lock: cover property (@(posedge i_clk) disable iff (!i_arst_n) o_search ##1 !o_search);
   c_loss: cover property (@(posedge i_clk) disable iff (!i_arst_n) expire);
   c_timeout: cover property (@(posedge i_clk) disable iff (!i_arst_n) timer_done);
   c_restart: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      st_q == bsf_pkg::BSF_LOCKED && i_rx.sync_found);
   c_masked_timeout: cover property (@(posedge i_clk) disable iff (!i_arst_n)
      timer_done && !i_irq_mask[bsf_pkg::FL_TIME_BIT]);
endmodule
`default_nettype wire

// ===== rtl/bsf_pkg.sv
// package: constants and carrier types for the block-sync flywheel and sleep timer
// ----------------------------------------------------------------------------
// Summary of operation
// - after first sync, capture decode/idle flags per block
// - predict next sync; early sync restarts prediction
// - prediction expiry: set sync flag, clear lock
// - reading pending flags clears timeout flag
// - countdown write loads 1..255 seconds, starts timer
// - timer expiry sets timeout flag and interrupt
// - timeout mask gates timer interrupt onto line
// - status holds decode bit 6, idle bit 5
// ----------------------------------------------------------------------------
package bsf_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned TICK_CYCLES = CLK_HZ;
   // received block layout, counted in bits from the end of the sync word
   localparam int unsigned BLOCK_BITS = 420;
   localparam int unsigned DEC_POS = 10;
   localparam int unsigned IDLE_POS = 11;
   localparam int unsigned SYNC_WINDOW = 4;
   // status and flag bit positions
   localparam int unsigned ST_LOCK_BIT = 7;
   localparam int unsigned ST_DEC_BIT = 6;
   localparam int unsigned ST_IDLE_BIT = 5;
   localparam int unsigned FL_SYNC_BIT = 7;
   localparam int unsigned FL_DEC_BIT = 6;
   localparam int unsigned FL_IDLE_BIT = 5;
   localparam int unsigned FL_TIME_BIT = 3;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] MASK_RST = 8'h00;

   typedef enum logic [1:0] {
      BSF_SEARCH = 2'b00,
      BSF_LOCKED = 2'b01
   } bsf_state_t;

   typedef struct packed {
      logic bit_valid;
      logic bit_value;
      logic sync_found;
   } bsf_rx_t;

   typedef struct packed {
      logic wr_valid;
      logic [7:0] seconds;
   } bsf_timer_wr_t;
endpackage

// ===== rtl/bsf_tick_div.sv
// module: divides the clock down to a one-cycle tick
`timescale 1ns/10ps
`default_nettype none
module bsf_tick_div #(
   parameter int unsigned DIV = 125_000_000
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_restart,
   output logic o_tick
);
   logic [31:0] cnt_q, cnt_d;
   logic tick_q, tick_d;

   // restart realigns so a freshly loaded count gets full seconds
   always_comb begin
      tick_d = 1'b0;
      cnt_d = cnt_q + 32'h0000_0001;
      if (i_restart) begin
         cnt_d = 32'h0000_0000;
      end else if (cnt_q == 32'(DIV - 1)) begin
         cnt_d = 32'h0000_0000;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign o_tick = tick_q;
endmodule
`default_nettype wire

// ===== sim/bsf_host_model.sv
// host model: sets masks, programs the sleep timer, reads pending flags
`timescale 1ns/10ps
`default_nettype none
module bsf_host_model (
   input wire logic i_clk,
   output var bsf_pkg::bsf_timer_wr_t o_timer_wr,
   output logic o_flags_rd,
   output logic [7:0] o_irq_mask
);
   initial begin
      o_timer_wr = '0;
      o_flags_rd = 1'b0;
      o_irq_mask = 8'h00;
   end
   task automatic set_mask(input logic [7:0] m);
      @(posedge i_clk);
      #1 o_irq_mask = m;
   endtask
   task automatic read_flags();
      @(posedge i_clk);
      #1 o_flags_rd = 1'b1;
      @(posedge i_clk);
      #1 o_flags_rd = 1'b0;
   endtask
   // a stale count on the released bus is inverted so it cannot pass for live data
   task automatic write_timer(input logic [7:0] secs);
      read_flags();
      @(posedge i_clk);
      #1 o_timer_wr = '{wr_valid: 1'b1, seconds: secs};
      @(posedge i_clk);
      #1 o_timer_wr = '{wr_valid: 1'b0, seconds: ~secs};
   endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench: flywheel lock, restart and loss, sleep timer and interrupt
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
   // ----------------------------------------------------------------
   // short counts keep the run brief
   // ----------------------------------------------------------------
   localparam int unsigned TICKS = 10;
   localparam int unsigned BLK = 20;
   logic i_clk, i_arst_n, flags_rd, o_symbols_valid, o_search, irq_out, irq_oe;
   bsf_pkg::bsf_rx_t i_rx;
   bsf_pkg::bsf_timer_wr_t timer_wr;
   logic [7:0] irq_mask, o_status, o_flags;
   logic [11:0] pat;
   int errors = 0;
   int check_count = 0;
   int unsigned secs;
   bsf_top #(.TICK_CYCLES(TICKS), .BLOCK_BITS(BLK)) u_bsf_top (.i_clk(i_clk),
      .i_arst_n(i_arst_n), .i_rx(i_rx), .i_timer_wr(timer_wr), .i_flags_rd(flags_rd),
      .i_irq_mask(irq_mask), .o_status(o_status), .o_flags(o_flags),
      .o_symbols_valid(o_symbols_valid), .o_search(o_search),
      .o_interrupt_line_n_out(irq_out), .o_interrupt_line_n_oe(irq_oe));
   bsf_host_model u_bsf_host_model (.i_clk(i_clk), .o_timer_wr(timer_wr),
      .o_flags_rd(flags_rd), .o_irq_mask(irq_mask));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic step(input int k);
      repeat (k) @(posedge i_clk);
      #1;
   endtask
   task automatic send_bit(input logic b);
      @(posedge i_clk);
      #1 i_rx = '{bit_valid: 1'b1, bit_value: b, sync_found: 1'b0};
      @(posedge i_clk);
      #1 i_rx = '{bit_valid: 1'b0, bit_value: ~b, sync_found: 1'b0};
   endtask
   task automatic send_sync();
      @(posedge i_clk);
      #1 i_rx.sync_found = 1'b1;
      @(posedge i_clk);
      #1 i_rx.sync_found = 1'b0;
   endtask
   task automatic results();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      results();
   end
   initial begin
      void'($urandom(32'h9650));
      i_rx = '0;
      i_arst_n = 1'b0;
      repeat (4) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      `CHK("reset status", 8'h00, o_status)
      `CHK("reset search", 1'b1, o_search)
      `CHK("line level", 1'b0, irq_out)
      `CHK("reset line", 1'b0, irq_oe)
      u_bsf_host_model.set_mask(8'h80);
      for (int r = 0; r < 3; r++) begin
         pat = (r == 0) ? 12'h400 : (r == 1) ? 12'h800 : 12'($urandom);
         u_bsf_host_model.read_flags();
         send_sync();
         step(1);
         `CHK("lock", 1'b1, o_status[7])
         `CHK("sync flag", 1'b1, o_flags[7])
         `CHK("search", 1'b0, o_search)
         for (int b = 0; b < 12; b++) send_bit(pat[b]);
         step(1);
         `CHK("decode", pat[10], o_status[6])
         `CHK("idle", pat[11], o_status[5])
         `CHK("decode flag", 1'b1, o_flags[6])
         `CHK("idle flag", 1'b1, o_flags[5])
         for (int b = 12; b < BLK; b++) send_bit(1'($urandom));
         // a sync inside the window must restart the prediction from zero
         send_sync();
         for (int b = 0; b < BLK; b++) send_bit(1'($urandom));
         step(1);
         `CHK("restart lock", 1'b1, o_symbols_valid)
         u_bsf_host_model.read_flags();
         `CHK("irq cleared", 1'b0, irq_oe)
         repeat (5) send_bit(1'($urandom));
         step(1);
         `CHK("loss status", 8'h00, o_status)
         `CHK("loss flag", 1'b1, o_flags[7])
         `CHK("loss search", 1'b1, o_search)
         `CHK("loss irq", 1'b1, irq_oe)
      end
      for (int t = 0; t < 4; t++) begin
         secs = (t == 0) ? 1 : (t == 3) ? 255 : 1 + $urandom % 4;
         u_bsf_host_model.set_mask({4'h0, t[0], 3'h0});
         u_bsf_host_model.write_timer(8'(secs));
         // the flag lands one clock after the tick that ends the last second
         step(secs * TICKS);
         `CHK("early flag", 1'b0, o_flags[3])
         step(1);
         `CHK("timeout flag", 1'b1, o_flags[3])
         `CHK("irq", t[0], irq_oe)
         u_bsf_host_model.read_flags();
         step(1);
         `CHK("cleared", 1'b0, o_flags[3])
      end
      results();
   end
endmodule
`default_nettype wire
